// >>> logic/pfs_top.sv
`timescale 1ns/1ps
module pfs_top (
  // Clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  // Register port
  input  wire logic [6:0]                          reg_addr,
  input  wire logic                                reg_wr,
  input  wire logic [7:0]                          reg_wdata,
  output logic      [7:0]                          reg_rdata,
  // Thresholds and interval length
  input  wire logic [pfs_pkg::SAMPLE_W-1:0]        voltage_peak_threshold,
  input  wire logic [pfs_pkg::SAMPLE_W-1:0]        current_peak_threshold,
  input  wire logic [pfs_pkg::COUNT_W-1:0]         half_cycle_count,
  // Samples and line timing
  input  wire logic [3*pfs_pkg::SAMPLE_W-1:0]      volt_samples,
  input  wire logic [3*pfs_pkg::SAMPLE_W-1:0]      curr_samples,
  input  wire logic                                sample_valid,
  input  wire logic                                half_cycle_tick,
  // Frequency source
  output logic      [1:0]                          frequency_source_select,
  output logic                                     freq_src_reserved,
  // Results and status
  output logic      [pfs_pkg::SAMPLE_W-1:0]        voltage_peak_result,
  output logic      [pfs_pkg::SAMPLE_W-1:0]        current_peak_result,
  output logic                                     peak_update,
  output logic      [2:0]                          volt_over_flags,
  output logic      [2:0]                          curr_over_flags,
  // Flag clear from status logic, per phase
  input  wire logic [2:0]                          volt_over_clr,
  input  wire logic [2:0]                          curr_over_clr
);
  // State of the block, apart from the two peak trackers, in one record. The mode fields come
  // first, then the interval counter and the two published peaks,
  // then the sticky flags and the registered readback byte. Every
  // output of the block is one of these fields, so no output ever
  // passes through gates after its flip-flop.
  typedef struct packed {
    // Mode register fields and the decoded reserved source code
    logic [1:0]                   freq_sel;
    logic                         fres;
    // Remaining mode fields, interval counter and published results
    logic [2:0]                   peak_sel;
    logic [2:0]                   thresh_sel;
    logic [pfs_pkg::COUNT_W-1:0]  hc_cnt;
    logic [pfs_pkg::SAMPLE_W-1:0] vpk;
    logic [pfs_pkg::SAMPLE_W-1:0] ipk;
    logic                         upd;
    // Sticky threshold flags and readback byte
    logic [2:0]                   vflag;
    logic [2:0]                   iflag;
    logic [7:0]                   rdata;
  } pfs_state_t;

  pfs_state_t s_q, s_d;
  logic [pfs_pkg::SAMPLE_W-1:0] vmax;
  logic [pfs_pkg::SAMPLE_W-1:0] imax;
  logic                         interval_end;

  // Magnitude of a signed sample; the most negative code wraps and is
  // read as the largest unsigned magnitude, so it still counts as big
  function automatic logic [pfs_pkg::SAMPLE_W-1:0] pfs_mag(
    input logic [pfs_pkg::SAMPLE_W-1:0] v);
    pfs_mag = v[pfs_pkg::SAMPLE_W-1] ? (~v + 1'b1) : v;
  endfunction

  // Address decode shared by the write and the readback paths
  function automatic logic pfs_mode_hit(
    input logic [6:0] a);
    pfs_mode_hit = (a == pfs_pkg::MEAS_MODE_OFFSET);
  endfunction

  // Strict compare of one monitored sample against its threshold;
  // a sample equal to the threshold does not count as a crossing
  function automatic logic pfs_over(
    input logic                         en,
    input logic [pfs_pkg::SAMPLE_W-1:0] smp,
    input logic [pfs_pkg::SAMPLE_W-1:0] thr);
    pfs_over = en && (pfs_mag(smp) > thr);
  endfunction

  // Next half-cycle count; the carry out of the top is cut on purpose
  // because the interval always closes before the counter can wrap
  function automatic logic [pfs_pkg::COUNT_W-1:0] pfs_next_cnt(
    input logic [pfs_pkg::COUNT_W-1:0] c);
    pfs_next_cnt = pfs_pkg::COUNT_W'(c + 1'b1);
  endfunction

  // Interval closes on the tick that completes the programmed count.
  // A count of zero or one closes every tick. The compare is greater
  // or equal, so a count lowered mid-interval still closes at once
  // instead of running on until the counter wraps.
  assign interval_end = half_cycle_tick &&
    (s_q.hc_cnt + 1'b1 >= half_cycle_count);

  // Separate trackers so each peak may come from a different phase.
  // Both share the phase selection and the interval restart; the
  // results are taken from them before the restart clears them, so
  // samples of the closing cycle count toward the next interval.
  pfs_peak_track u_vtrack (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .samples      (volt_samples),
    .sample_valid (sample_valid),
    .phase_en     (s_q.peak_sel),
    .restart      (interval_end),
    .running_max  (vmax)
  );

  pfs_peak_track u_itrack (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .samples      (curr_samples),
    .sample_valid (sample_valid),
    .phase_en     (s_q.peak_sel),
    .restart      (interval_end),
    .running_max  (imax)
  );

  // Next-state logic for register, interval and flags
  always_comb begin
    s_d     = s_q;
    s_d.upd = 1'b0;

    // Register write; this block decodes only its own address and
    // leaves every other one to the rest of the register file
    if (reg_wr && pfs_mode_hit(reg_addr)) begin
      s_d.freq_sel   = reg_wdata[pfs_pkg::FREQ_SEL_LSB +: 2];
      s_d.peak_sel   = reg_wdata[pfs_pkg::PEAK_SEL_LSB +: 3];
      s_d.thresh_sel = reg_wdata[pfs_pkg::THRESH_SEL_LSB +: 3];
    end

    // Reserved source code kept in its own flop, decoded from the
    // next field value so it changes in the same cycle as the field
    s_d.fres = s_d.freq_sel[1] & s_d.freq_sel[0];

    // Readback shows the value before a same-cycle write lands; the
    // new value is seen one cycle later. Other addresses read zero.
    if (pfs_mode_hit(reg_addr)) begin
      s_d.rdata = {s_q.thresh_sel, s_q.peak_sel, s_q.freq_sel};
    end else begin
      s_d.rdata = 8'h00;
    end

    // Half-cycle counting and result replacement. The counter is not
    // touched by mode writes, so a new phase selection applies to the
    // interval already running; software that needs a clean interval
    // should discard the first result after changing the selection.
    if (interval_end) begin
      s_d.hc_cnt = '0;
      s_d.vpk    = vmax;
      s_d.ipk    = imax;
      s_d.upd    = 1'b1;
    end else if (half_cycle_tick) begin
      s_d.hc_cnt = pfs_next_cnt(s_q.hc_cnt);
    end

    // Threshold flags: clear first so a same-cycle event wins, which
    // keeps a crossing from being lost while status is acknowledged
    s_d.vflag = s_q.vflag & ~volt_over_clr;
    s_d.iflag = s_q.iflag & ~curr_over_clr;
    if (sample_valid) begin
      for (int p = 0; p < 3; p++) begin
        if (pfs_over(s_q.thresh_sel[p],
                     volt_samples[p*pfs_pkg::SAMPLE_W +: pfs_pkg::SAMPLE_W],
                     voltage_peak_threshold)) begin
          s_d.vflag[p] = 1'b1;
        end
        if (pfs_over(s_q.thresh_sel[p],
                     curr_samples[p*pfs_pkg::SAMPLE_W +: pfs_pkg::SAMPLE_W],
                     current_peak_threshold)) begin
          s_d.iflag[p] = 1'b1;
        end
      end
    end
  end

  // State register; reset loads the documented field defaults and
  // clears results, flags and the interval counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q            <= '0;
      s_q.freq_sel   <= pfs_pkg::FREQ_SEL_RESET;
      s_q.peak_sel   <= pfs_pkg::PEAK_SEL_RESET;
      s_q.thresh_sel <= pfs_pkg::THRESH_SEL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops; the reserved source code is
  // flagged so the period logic can hold off
  assign reg_rdata               = s_q.rdata;
  assign frequency_source_select = s_q.freq_sel;
  assign voltage_peak_result     = s_q.vpk;
  assign current_peak_result     = s_q.ipk;
  assign peak_update             = s_q.upd;
  assign volt_over_flags         = s_q.vflag;
  assign curr_over_flags         = s_q.iflag;
  assign freq_src_reserved       = s_q.fres;
endmodule

// >>> logic/pfs_pkg.sv
package pfs_pkg;
  // Register map
  localparam logic [6:0] MEAS_MODE_OFFSET  = 7'h14;
  // Field positions
  localparam int FREQ_SEL_LSB   = 0;
  localparam int PEAK_SEL_LSB   = 2;
  localparam int THRESH_SEL_LSB = 5;
  // Reset values
  localparam logic [1:0] FREQ_SEL_RESET   = 2'h0;
  localparam logic [2:0] PEAK_SEL_RESET   = 3'h7;
  localparam logic [2:0] THRESH_SEL_RESET = 3'h7;
  // Sample, result and interval counter widths
  localparam int SAMPLE_W = 24;
  localparam int COUNT_W  = 16;
  // Phase numbering of the frequency source field
  localparam logic [1:0] SRC_PHASE_A = 2'h0;
  localparam logic [1:0] SRC_PHASE_B = 2'h1;
  localparam logic [1:0] SRC_PHASE_C = 2'h2;
endpackage

// >>> logic/pfs_peak_track.sv
`timescale 1ns/1ps
// Running maximum of absolute samples over the enabled phases
module pfs_peak_track (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // Sample input, one per phase
  input  wire logic [3*pfs_pkg::SAMPLE_W-1:0] samples,
  input  wire logic                          sample_valid,
  input  wire logic [2:0]                    phase_en,
  // Interval control and result
  input  wire logic                          restart,
  output logic      [pfs_pkg::SAMPLE_W-1:0]  running_max
);
  typedef struct packed {
    logic [pfs_pkg::SAMPLE_W-1:0] max;
  } pfs_trk_state_t;

  pfs_trk_state_t s_q, s_d;

  function automatic logic [pfs_pkg::SAMPLE_W-1:0] pfs_abs(
    input logic [pfs_pkg::SAMPLE_W-1:0] v);
    pfs_abs = v[pfs_pkg::SAMPLE_W-1] ? (~v + 1'b1) : v;
  endfunction

  // Maximum over selected phases; restart clears to zero first
  always_comb begin
    logic [pfs_pkg::SAMPLE_W-1:0] m;
    logic [pfs_pkg::SAMPLE_W-1:0] a;
    s_d = s_q;
    m = restart ? '0 : s_q.max;
    a = '0;
    if (sample_valid) begin
      for (int p = 0; p < 3; p++) begin
        a = pfs_abs(samples[p*pfs_pkg::SAMPLE_W +: pfs_pkg::SAMPLE_W]);
        if (phase_en[p] && a > m) begin
          m = a;
        end
      end
    end
    s_d.max = m;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign running_max = s_q.max;
endmodule

// >>> tb/pfs_top_monitor.sv
`timescale 1ns/1ps
module pfs_top_monitor (
  // Clock, reset and register port
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  // Line timing and results
  input wire logic        sample_valid,
  input wire logic        half_cycle_tick,
  input wire logic [1:0]  frequency_source_select,
  input wire logic        freq_src_reserved,
  input wire logic [23:0] voltage_peak_result,
  input wire logic        peak_update,
  // Threshold flags
  input wire logic [2:0]  volt_over_flags,
  input wire logic [2:0]  curr_over_flags,
  input wire logic [2:0]  volt_over_clr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Field, reset and result relations
  reserved_flag_a: assert property (
    freq_src_reserved == (frequency_source_select == 2'h3))
    else $error("bad reserved flag");
  write_field_a: assert property (
    reg_wr && reg_addr == 7'h14 |=>
    frequency_source_select == $past(reg_wdata[1:0]))
    else $error("field not written");
  reset_state_a: assert property (
    $fell(rst) |->
    frequency_source_select == 2'h0 && volt_over_flags == 3'h0)
    else $error("bad reset state");
  result_load_a: assert property (
    $changed(voltage_peak_result) |-> peak_update)
    else $error("result moved without update");
  update_cause_a: assert property (
    peak_update |-> $past(half_cycle_tick))
    else $error("update without tick");
  // Flags rise only on a sample and stay until cleared
  volt_set_a: assert property (
    $rose(volt_over_flags[1]) |-> $past(sample_valid))
    else $error("voltage flag without sample");
  curr_set_a: assert property (
    $rose(curr_over_flags[2]) |-> $past(sample_valid))
    else $error("current flag without sample");
  flag_hold_a: assert property (
    volt_over_flags[1] && !volt_over_clr[1] |=> volt_over_flags[1])
    else $error("flag dropped");
  flag_clear_a: assert property (
    volt_over_clr[1] && !sample_valid |=> !volt_over_flags[1])
    else $error("flag not cleared");
  cover property (peak_update);
  cover property (freq_src_reserved);
  cover property ($rose(volt_over_flags[1]));
  cover property (volt_over_clr[0] && sample_valid);
endmodule

// >>> tb/test_pfs_top.sv
`timescale 1ns/1ps
module test_pfs_top;
  logic        ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0;
  logic        sample_valid = 1'b0, half_cycle_tick = 1'b0;
  logic        freq_src_reserved, peak_update;
  logic [6:0]  reg_addr = 7'h14;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic [1:0]  frequency_source_select;
  logic [15:0] half_cycle_count = 16'h0001;
  logic [23:0] voltage_peak_threshold = 24'h32;
  logic [23:0] current_peak_threshold = 24'h32;
  logic [23:0] voltage_peak_result, current_peak_result;
  logic [71:0] volt_samples = '0, curr_samples = '0;
  logic [2:0]  volt_over_flags, curr_over_flags;
  logic [2:0]  volt_over_clr = 3'h0, curr_over_clr = 3'h0;
  int          n_errors = 0, check_count = 0;
  pfs_top DUT (.*);
  // Clock and watchdog; the run needs well under 20 us
  initial forever #20 ref_clk = ~ref_clk;
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [23:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic smp(input logic [71:0] v, i);
    volt_samples = v;
    curr_samples = i;
    sample_valid = 1'b1;
    cyc(1);
    sample_valid = 1'b0;
    cyc(1);
  endtask
  // Pulses one half-cycle tick; bounded wait for the update pulse
  task automatic tick;
    half_cycle_tick = 1'b1;
    cyc(1);
    half_cycle_tick = 1'b0;
    for (int k = 0; k < 9 && peak_update !== 1'b1; k++) cyc(1);
  endtask
  task automatic t_reg;
    chk("reset mode", 24'hfc, {16'h0, reg_rdata});
    for (int k = 0; k < 4; k++) begin
      wr(7'h14, 8'hfc | k[7:0]);
      chk("fsel", k[23:0], {22'h0, frequency_source_select});
      chk("fres", {23'h0, k == 3}, {23'h0, freq_src_reserved});
    end
    wr(7'h15, 8'h00);
    chk("unmapped", 24'h0, {16'h0, reg_rdata});
    reg_addr = 7'h14;
    cyc(2);
    chk("readback", 24'hff, {16'h0, reg_rdata});
  endtask
  task automatic t_peak(input logic [7:0] m, input logic [71:0] v, i,
                        input logic [23:0] ev, ei);
    wr(7'h14, m);
    tick();
    smp(v, i);
    tick();
    chk("voltage_peak_result", ev, voltage_peak_result);
    chk("current_peak_result", ei, current_peak_result);
  endtask
  task automatic t_flag;
    wr(7'h14, 8'hc0);
    smp({24'h0, 24'h32, 24'h63}, {24'h0, 24'h0, 24'h63});
    chk("no flag", 24'h0, {21'h0, volt_over_flags});
    smp({24'h0, 24'hffffcd, 24'h0}, {24'h33, 24'h0, 24'h0});
    chk("vflag", 24'h2, {21'h0, volt_over_flags});
    chk("cflag", 24'h4, {21'h0, curr_over_flags});
    volt_over_clr = 3'h2;
    curr_over_clr = 3'h4;
    cyc(1);
    volt_over_clr = 3'h0;
    curr_over_clr = 3'h0;
    cyc(1);
    chk("vclear", 24'h0, {21'h0, volt_over_flags});
    chk("cclear", 24'h0, {21'h0, curr_over_flags});
    // Phase A monitor, with a clear in the same cycle as the crossing
    wr(7'h14, 8'h20);
    volt_samples = {48'h0, 24'h40};
    sample_valid = 1'b1;
    volt_over_clr = 3'h1;
    cyc(1);
    sample_valid = 1'b0;
    volt_over_clr = 3'h0;
    cyc(1);
    chk("set wins", 24'h1, {21'h0, volt_over_flags});
  endtask
  // Interval of three half cycles: results move only on the third tick
  task automatic t_count;
    half_cycle_count = 16'h0003;
    wr(7'h14, 8'h04);
    tick();
    chk("no update 1", 24'h0, {23'h0, peak_update});
    smp({48'h0, 24'h11}, {48'h0, 24'h22});
    tick();
    chk("no update 2", 24'h0, {23'h0, peak_update});
    tick();
    chk("update", 24'h1, {23'h0, peak_update});
    chk("voltage_peak_result count", 24'h11, voltage_peak_result);
    chk("current_peak_result count", 24'h22, current_peak_result);
    half_cycle_count = 16'h0001;
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    cyc(12);
    rst = 1'b0;
    cyc(2);
    t_reg();
    t_peak(8'h04, {24'h64, 24'h64, 24'hfffffb}, {24'h0, 24'h32, 24'h7},
           24'h5, 24'h7);
    t_peak(8'h18, {24'h9, 24'h1e, 24'h32}, {24'hffffe0, 24'h4, 24'h3c},
           24'h1e, 24'h20);
    t_peak(8'h10, {24'h3, 24'h63, 24'h63}, {24'h2, 24'h0, 24'h0},
           24'h3, 24'h2);
    t_flag();
    t_count();
    final_report();
  end
endmodule
bind pfs_top pfs_top_monitor MON (.*);
